// file: mtg_gateway_defs.vh
// Constants for the Modbus/TCP to RTU gateway core.
// Assumes inclusion by mtg_gateway.v only.
`ifndef MTG_GATEWAY_DEFS_VH
`define MTG_GATEWAY_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define MTG_ADDR_CMD 8'h00
`define MTG_ADDR_WAIT 8'h04
`define MTG_ADDR_RETRY 8'h08
`define MTG_ADDR_NATIVE 8'h0c
`define MTG_ADDR_STATUS 8'h10
`define MTG_ADDR_IRQ_STAT 8'h14
`define MTG_ADDR_IRQ_MASK 8'h18

// ----------------------------------------------------------------
// Command selectors and fields
// ----------------------------------------------------------------
`define MTG_SEL_WAIT 8'h01
`define MTG_SEL_RETRY 8'h02
`define MTG_SEL_GATEWAY 8'h0c
`define MTG_CMD_SEL_HI 15
`define MTG_CMD_SEL_LO 8
`define MTG_PORT_MIN 2'h1
`define MTG_PORT_MAX 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MTG_WAIT_RST 8'h55
`define MTG_RETRY_RST 8'haa
`define MTG_NATIVE_RST 8'h01

// ----------------------------------------------------------------
// Exception encoding
// ----------------------------------------------------------------
`define MTG_EXC_BIT 7
`define MTG_EXC_NO_RESPONSE 8'h0b
`define MTG_EXC_BUSY 8'h06

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define MTG_IRQ_DONE 0
`define MTG_IRQ_FAIL 1
`define MTG_IRQ_BUSY 2
`define MTG_IRQ_W 3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MTG_WAIT_STATE_MS 150
`define MTG_CLK_KHZ 10000
`define MTG_WAIT_STATE_CYC (`MTG_WAIT_STATE_MS * `MTG_CLK_KHZ)

`endif

// file: mtg_gateway.v
// Modbus/TCP to Modbus RTU gateway core: routing, retries, time-outs.
// Assumes all inputs come from logic on ref_clk_i (TCP stack, UARTs,
// program sequencer), so none is synchronised here.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "mtg_gateway_defs.vh"

module mtg_gateway #(
  parameter CONN_W = 2,
  parameter WAIT_CYC = `MTG_WAIT_STATE_CYC
)
(
  input wire ref_clk_i,
  input wire resetn_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output reg irq_o,
  input wire scan_i,
  input wire req_valid_i,
  input wire [7:0] req_id_i,
  input wire [7:0] req_func_i,
  input wire [CONN_W-1:0] req_conn_i,
  output reg local_valid_o,
  output reg [7:0] local_func_o,
  output reg [CONN_W-1:0] local_conn_o,
  output reg tx_valid_o,
  output reg [1:0] tx_port_o,
  output reg [7:0] tx_id_o,
  output reg [7:0] tx_func_o,
  input wire rx_valid_i,
  input wire [1:0] rx_port_i,
  input wire [7:0] rx_func_i,
  output reg rsp_valid_o,
  output reg rsp_exc_o,
  output reg [7:0] rsp_id_o,
  output reg [7:0] rsp_func_o,
  output reg [7:0] rsp_code_o,
  output reg [CONN_W-1:0] rsp_conn_o,
  output reg busy_valid_o,
  output reg [7:0] busy_id_o,
  output reg [7:0] busy_func_o,
  output reg [CONN_W-1:0] busy_conn_o,
  input wire mst_req_i,
  input wire mst_done_i,
  output reg mst_grant_o
);

  localparam CONNS = 1 << CONN_W;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SEND = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [1:0] ST_MST = 2'h3;
  localparam [23:0] WAIT_UNIT = WAIT_CYC[23:0];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Two-bit per-port field of a wait or retry byte
  function [1:0] port_field;
    input [7:0] cfg;
    input [1:0] port;
    begin
      case (port)
        2'h1: port_field = cfg[1:0];
        2'h2: port_field = cfg[3:2];
        2'h3: port_field = cfg[5:4];
        default: port_field = cfg[7:6];
      endcase
    end
  endfunction

  // Time-out length for a number of wait states, never below one cycle
  function [23:0] wait_len;
    input [1:0] states;
    reg [25:0] prod;
    begin
      prod = {24'h000000, states} * {2'h0, WAIT_UNIT};
      if (states == 2'h0)
        wait_len = 24'h000001;
      else
        wait_len = prod[23:0];
    end
  endfunction

  // Exception answer: function code with its top bit set
  function [7:0] exc_func;
    input [7:0] func;
    begin
      exc_func = func | (8'h01 << `MTG_EXC_BIT);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg gw_en;
  reg [1:0] gw_port;
  reg [7:0] wait_cfg;
  reg [7:0] retry_cfg;
  reg [7:0] native_id;
  reg [`MTG_IRQ_W-1:0] irq_stat;
  reg [`MTG_IRQ_W-1:0] irq_mask;
  reg [1:0] state;
  reg [1:0] tries;
  reg [23:0] timer;
  reg [7:0] cur_id;
  reg [7:0] cur_func;
  reg [CONN_W-1:0] cur_conn;
  reg [CONNS-1:0] conn_used;

  wire [7:0] cmd_sel = wdata_i[`MTG_CMD_SEL_HI:`MTG_CMD_SEL_LO];
  wire [7:0] cmd_val = wdata_i[7:0];
  wire is_native = req_id_i == native_id;
  wire fwd_req = req_valid_i && !is_native && gw_en;
  wire take_req = fwd_req && state == ST_IDLE && !conn_used[req_conn_i];
  // Replies on another port or outside the wait are ignored
  wire rx_hit = state == ST_WAIT && rx_valid_i && rx_port_i == gw_port;
  wire expired = state == ST_WAIT && !rx_hit && timer == 24'h000001;
  wire fail = expired && tries == 2'h0;
  wire [`MTG_IRQ_W-1:0] irq_set = {fwd_req && !take_req, fail, rx_hit};
  // Status word: retries left, state, current ID and function
  wire [31:0] status_word = {10'h000, tries, 2'h0, state, cur_id, cur_func};

  // ----------------------------------------------------------------
  // Register writes and configuration commands
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      gw_en <= 1'b0;
      gw_port <= `MTG_PORT_MIN;
      wait_cfg <= `MTG_WAIT_RST;
      retry_cfg <= `MTG_RETRY_RST;
      native_id <= `MTG_NATIVE_RST;
      irq_mask <= {`MTG_IRQ_W{1'b0}};
    end
    else if (wr_i)
    begin
      if (addr_i == `MTG_ADDR_CMD)
      begin
        if (cmd_sel == `MTG_SEL_GATEWAY && cmd_val[7:2] == 6'h00 &&
            cmd_val[1:0] >= `MTG_PORT_MIN)
        begin
          gw_en <= 1'b1;
          gw_port <= cmd_val[1:0];
        end
        else if (cmd_sel == `MTG_SEL_WAIT)
          wait_cfg <= cmd_val;
        else if (cmd_sel == `MTG_SEL_RETRY)
          retry_cfg <= cmd_val;
      end
      else if (addr_i == `MTG_ADDR_WAIT)
        wait_cfg <= cmd_val;
      else if (addr_i == `MTG_ADDR_RETRY)
        retry_cfg <= cmd_val;
      else if (addr_i == `MTG_ADDR_NATIVE)
        native_id <= cmd_val;
      else if (addr_i == `MTG_ADDR_IRQ_MASK)
        irq_mask <= wdata_i[`MTG_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      irq_stat <= {`MTG_IRQ_W{1'b0}};
      irq_o <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == `MTG_ADDR_IRQ_STAT)
        irq_stat <= (irq_stat & ~wdata_i[`MTG_IRQ_W-1:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
      // Level output lags the status by one cycle
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Register reads, data in the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
    begin
      if (addr_i == `MTG_ADDR_CMD)
        rdata_o <= {29'h00000000, gw_en, gw_port};
      else if (addr_i == `MTG_ADDR_WAIT)
        rdata_o <= {24'h000000, wait_cfg};
      else if (addr_i == `MTG_ADDR_RETRY)
        rdata_o <= {24'h000000, retry_cfg};
      else if (addr_i == `MTG_ADDR_NATIVE)
        rdata_o <= {24'h000000, native_id};
      else if (addr_i == `MTG_ADDR_STATUS)
        rdata_o <= status_word;
      else if (addr_i == `MTG_ADDR_IRQ_STAT)
        rdata_o <= {29'h00000000, irq_stat};
      else if (addr_i == `MTG_ADDR_IRQ_MASK)
        rdata_o <= {29'h00000000, irq_mask};
      else
        rdata_o <= 32'h00000000;
    end
    else
      rdata_o <= 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Per-scan translation budget
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      conn_used <= {CONNS{1'b0}};
    // An accept in the scan cycle keeps its budget bit
    else if (scan_i)
      conn_used <= take_req ? ({{(CONNS-1){1'b0}}, 1'b1} << req_conn_i) :
        {CONNS{1'b0}};
    else if (take_req)
      conn_used[req_conn_i] <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Local answers and busy rejects
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      local_valid_o <= 1'b0;
      local_func_o <= 8'h00;
      local_conn_o <= {CONN_W{1'b0}};
      busy_valid_o <= 1'b0;
      busy_id_o <= 8'h00;
      busy_func_o <= 8'h00;
      busy_conn_o <= {CONN_W{1'b0}};
    end
    else
    begin
      local_valid_o <= req_valid_i && is_native;
      local_func_o <= req_func_i;
      local_conn_o <= req_conn_i;
      busy_valid_o <= fwd_req && !take_req;
      busy_id_o <= req_id_i;
      busy_func_o <= exc_func(req_func_i);
      busy_conn_o <= req_conn_i;
    end
  end

  // ----------------------------------------------------------------
  // Serial port sequencer
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_IDLE;
      tries <= 2'h0;
      timer <= 24'h000000;
      cur_id <= 8'h00;
      cur_func <= 8'h00;
      cur_conn <= {CONN_W{1'b0}};
      tx_valid_o <= 1'b0;
      tx_port_o <= `MTG_PORT_MIN;
      tx_id_o <= 8'h00;
      tx_func_o <= 8'h00;
      rsp_valid_o <= 1'b0;
      rsp_exc_o <= 1'b0;
      rsp_id_o <= 8'h00;
      rsp_func_o <= 8'h00;
      rsp_code_o <= 8'h00;
      rsp_conn_o <= {CONN_W{1'b0}};
      mst_grant_o <= 1'b0;
    end
    else
    begin
      tx_valid_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      mst_grant_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (take_req)
          begin
            cur_id <= req_id_i;
            cur_func <= req_func_i;
            cur_conn <= req_conn_i;
            tries <= port_field(retry_cfg, gw_port);
            state <= ST_SEND;
          end
          else if (mst_req_i)
          begin
            mst_grant_o <= 1'b1;
            state <= ST_MST;
          end
        end
        ST_SEND:
        begin
          tx_valid_o <= 1'b1;
          tx_port_o <= gw_port;
          tx_id_o <= cur_id;
          tx_func_o <= cur_func;
          timer <= wait_len(port_field(wait_cfg, gw_port));
          state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          // A reply in the expiry cycle still wins
          if (rx_hit)
          begin
            rsp_valid_o <= 1'b1;
            rsp_exc_o <= 1'b0;
            rsp_id_o <= cur_id;
            rsp_func_o <= rx_func_i;
            rsp_code_o <= 8'h00;
            rsp_conn_o <= cur_conn;
            state <= ST_IDLE;
          end
          else if (fail)
          begin
            rsp_valid_o <= 1'b1;
            rsp_exc_o <= 1'b1;
            rsp_id_o <= cur_id;
            rsp_func_o <= exc_func(cur_func);
            rsp_code_o <= `MTG_EXC_NO_RESPONSE;
            rsp_conn_o <= cur_conn;
            state <= ST_IDLE;
          end
          else if (expired)
          begin
            tries <= tries - 2'h1;
            state <= ST_SEND;
          end
          else
            timer <= timer - 24'h000001;
        end
        default:
        begin
          // Own master transaction holds the port until it reports done
          if (mst_done_i)
            state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: mtg_gateway_assertions.sv
// Port checker for the gateway core.
// Assumes one clock domain and a bind onto mtg_gateway.
`timescale 1ns/1ps
module mtg_gateway_chk (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire req_valid_i,
  input wire local_valid_o,
  input wire tx_valid_o,
  input wire [1:0] tx_port_o,
  input wire rx_valid_i,
  input wire [7:0] rx_func_i,
  input wire rsp_valid_o,
  input wire rsp_exc_o,
  input wire [7:0] rsp_func_o,
  input wire [7:0] rsp_code_o,
  input wire busy_valid_o,
  input wire [7:0] busy_func_o,
  input wire mst_req_i,
  input wire mst_grant_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  AST_LOCAL_CAUSE: assert property (local_valid_o |-> $past(req_valid_i))
    else $error("local answer without a request");
  AST_BUSY_EXC: assert property (busy_valid_o |-> $past(req_valid_i) && busy_func_o[7])
    else $error("busy answer malformed");
  AST_TX_PORT: assert property (tx_valid_o |-> tx_port_o inside {[2'h1:2'h3]})
    else $error("command sent on no serial port");
  AST_TX_GAP: assert property (tx_valid_o |=> !tx_valid_o)
    else $error("resend without waiting");
  AST_FAIL_CODE: assert property (rsp_valid_o && rsp_exc_o |-> rsp_func_o[7] && rsp_code_o == 8'h0b)
    else $error("failure answer malformed");
  AST_REPLY: assert property (rsp_valid_o && !rsp_exc_o |->
    $past(rx_valid_i) && rsp_func_o == $past(rx_func_i) && rsp_code_o == 8'h00)
    else $error("reply not passed through");
  AST_GRANT: assert property (mst_grant_o |-> $past(mst_req_i) && !tx_valid_o)
    else $error("grant without master request");
  AST_RDATA: assert property (rdata_o != 32'h0 |-> $past(rd_i))
    else $error("read data outside read answer");
endmodule

bind mtg_gateway mtg_gateway_chk u_chk (.ref_clk_i, .resetn_i, .rd_i, .rdata_o, .req_valid_i,
  .local_valid_o, .tx_valid_o, .tx_port_o, .rx_valid_i, .rx_func_i, .rsp_valid_o, .rsp_exc_o,
  .rsp_func_o, .rsp_code_o, .busy_valid_o, .busy_func_o, .mst_req_i, .mst_grant_o);

// file: mtg_rtu_slave.sv
// Serial slave model: answers each command after a set delay.
// Assumes the bench sets mute and delay (delay of one or more).
`timescale 1ns/1ps
module mtg_rtu_slave (
  input wire ref_clk_i,
  input wire tx_valid_i,
  input wire [1:0] tx_port_i,
  input wire [7:0] tx_func_i,
  input wire mute_i,
  input wire [3:0] delay_i,
  output logic rx_valid_o = 1'b0,
  output logic [1:0] rx_port_o = 2'h0,
  output logic [7:0] rx_func_o = 8'h00
);
  logic [3:0] cnt = 4'h0;
  logic [1:0] port = 2'h0;
  logic [7:0] func = 8'h00;
  // Only replies, never commands of its own
  always @(posedge ref_clk_i)
  begin
    rx_valid_o <= 1'b0;
    rx_port_o <= ~rx_port_o;
    rx_func_o <= ~rx_func_o;
    if (tx_valid_i && !mute_i)
    begin
      cnt <= delay_i;
      port <= tx_port_i;
      func <= tx_func_i;
    end
    else if (cnt != 4'h0)
    begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1)
      begin
        rx_valid_o <= 1'b1;
        rx_port_o <= port;
        rx_func_o <= func;
      end
    end
  end
endmodule

// file: test_mtg_gateway.sv
// Self-checking bench for the gateway core with a serial slave model.
// Assumes a shortened wait state of WC cycles.
`timescale 1ns/1ps
module test_mtg_gateway;
  localparam int WC = 8;
  logic ref_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, scan_i = 0, req_valid_i = 0;
  logic mst_req_i = 0, mst_done_i = 0, mute = 0, irq_o, local_valid_o, tx_valid_o;
  logic rx_valid_i, rsp_valid_o, rsp_exc_o, busy_valid_o, mst_grant_o;
  logic [7:0] addr_i = 0, req_id_i = 0, req_func_i = 0, local_func_o, tx_id_o, tx_func_o;
  logic [7:0] rx_func_i, rsp_id_o, rsp_func_o, rsp_code_o, busy_id_o, busy_func_o, id, fn;
  logic [1:0] req_conn_i = 0, local_conn_o, tx_port_o, rx_port_i, rsp_conn_o, busy_conn_o;
  logic [31:0] wdata_i = 0, rdata_o;
  logic [3:0] dly = 4'h1;
  integer seed = 32'he72d0bbf;
  int fail_count = 0, tests_run = 0, n_tx = 0, n_rsp = 0, n_loc = 0, n_busy = 0, n_gnt = 0;
  int cyc_n = 0, t_tx = 0, t_rsp = 0, b0, r0;
  mtg_gateway #(.CONN_W(2), .WAIT_CYC(WC)) dut (.ref_clk_i, .resetn_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .irq_o, .scan_i, .req_valid_i, .req_id_i, .req_func_i, .req_conn_i,
    .local_valid_o, .local_func_o, .local_conn_o, .tx_valid_o, .tx_port_o, .tx_id_o, .tx_func_o,
    .rx_valid_i, .rx_port_i, .rx_func_i, .rsp_valid_o, .rsp_exc_o, .rsp_id_o, .rsp_func_o,
    .rsp_code_o, .rsp_conn_o, .busy_valid_o, .busy_id_o, .busy_func_o, .busy_conn_o,
    .mst_req_i, .mst_done_i, .mst_grant_o);
  mtg_rtu_slave slave (.ref_clk_i, .tx_valid_i(tx_valid_o), .tx_port_i(tx_port_o),
    .tx_func_i(tx_func_o), .mute_i(mute), .delay_i(dly), .rx_valid_o(rx_valid_i),
    .rx_port_o(rx_port_i), .rx_func_o(rx_func_i));
  initial
  begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // Pulse counters and event times
  always @(posedge ref_clk_i)
  begin
    cyc_n++;
    if (tx_valid_o === 1'b1)
    begin
      n_tx++;
      t_tx = cyc_n;
    end
    if (rsp_valid_o === 1'b1)
    begin
      n_rsp++;
      t_rsp = cyc_n;
    end
    n_loc += (local_valid_o === 1'b1);
    n_busy += (busy_valid_o === 1'b1);
    n_gnt += (mst_grant_o === 1'b1);
  end
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 0;
    #1 chk(rdata_o, e);
  endtask
  task req(input logic [7:0] i, input logic [7:0] f, input logic [1:0] c);
    @(posedge ref_clk_i);
    req_valid_i <= 1;
    req_id_i <= i;
    req_func_i <= f;
    req_conn_i <= c;
    @(posedge ref_clk_i);
    req_valid_i <= 0;
  endtask
  task scan;
    @(posedge ref_clk_i);
    scan_i <= 1;
    @(posedge ref_clk_i);
    scan_i <= 0;
  endtask
  task wait_rsp(input int r);
    for (int i = 0; i < 400 && n_rsp == r; i++) @(posedge ref_clk_i);
    chk(n_rsp, r + 1);
    cyc(1);
  endtask
  initial
  begin
    cyc(20000);
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    cyc(8);
    resetn_i <= 1;
    rd(8'h04, 32'h55);
    rd(8'h08, 32'haa);
    rd(8'h00, 32'h1);
    rd(8'h30, 32'h0);
    req(8'h22, 8'h03, 2'h0);
    cyc(6);
    chk(n_tx + n_busy + n_rsp, 0);
    wr(8'h00, 32'h0c00);
    rd(8'h00, 32'h1);
    wr(8'h00, 32'h0c02);
    rd(8'h00, 32'h6);
    req(8'h01, 8'h04, 2'h1);
    cyc(4);
    chk(n_loc, 1);
    chk(n_tx, 0);
    chk({local_func_o, 6'h00, local_conn_o}, {8'h04, 6'h00, 2'h1});
    repeat (4)
    begin
      id = 8'h02 + ($random(seed) & 8'h7f);
      fn = 8'h01 + ($random(seed) & 8'h3f);
      dly = 4'h1 + ($random(seed) & 4'h3);
      r0 = n_rsp;
      b0 = n_busy;
      req(id, fn, id[1:0]);
      wait_rsp(r0);
      chk({tx_port_o, tx_id_o, tx_func_o}, {2'h2, id, fn});
      chk({rsp_exc_o, rsp_id_o, rsp_func_o, rsp_conn_o, rsp_code_o}, {1'b0, id, fn, id[1:0], 8'h00});
      req(id, fn, id[1:0]);
      cyc(3);
      chk(n_busy, b0 + 1);
      chk({busy_func_o, busy_id_o, 6'h00, busy_conn_o}, {fn | 8'h80, id, 6'h00, id[1:0]});
      scan;
    end
    rd(8'h14, 32'h5);
    mute <= 1;
    wr(8'h14, 32'h7);
    wr(8'h18, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      wr(8'h00, 32'h0200 | (r << 2));
      scan;
      b0 = n_tx;
      r0 = n_rsp;
      req(8'h33, 8'h05, r[1:0]);
      wait_rsp(r0);
      chk(n_tx - b0, r + 1);
      chk({rsp_exc_o, rsp_func_o, rsp_code_o}, {1'b1, 8'h85, 8'h0b});
      chk(t_rsp - t_tx, WC);
      cyc(20);
    end
    chk(irq_o, 0);
    rd(8'h14, 32'h2);
    wr(8'h18, 32'h2);
    cyc(2);
    chk(irq_o, 1);
    wr(8'h14, 32'h2);
    cyc(2);
    chk(irq_o, 0);
    wr(8'h00, 32'h0100);
    wr(8'h00, 32'h015d);
    rd(8'h04, 32'h5d);
    scan;
    r0 = n_rsp;
    req(8'h44, 8'h06, 2'h1);
    wait_rsp(r0);
    chk(t_rsp - t_tx, 3 * WC);
    scan;
    mst_req_i <= 1;
    cyc(3);
    chk(n_gnt, 1);
    b0 = n_busy;
    req(8'h45, 8'h03, 2'h2);
    cyc(3);
    chk(n_busy, b0 + 1);
    mst_req_i <= 0;
    mst_done_i <= 1;
    cyc(1);
    mst_done_i <= 0;
    cyc(4);
    rd(8'h10, 32'h4406);
    rd(8'h18, 32'h2);
    rd(8'h0c, 32'h1);
    wr(8'h0c, 32'h45);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h0);
    r0 = n_loc;
    b0 = n_tx;
    req(8'h45, 8'h07, 2'h3);
    cyc(3);
    chk(n_loc - r0, 1);
    chk({local_func_o, 6'h00, local_conn_o}, {8'h07, 6'h00, 2'h3});
    chk(n_tx - b0, 0);
    tally_and_finish;
  end
endmodule
